// ==== shrp_pkg.sv ====
// Constants shared by both ends of the serial host register port
package shrp_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 4;
  localparam int TIM_W = 8;
  localparam int RW_BIT = 15;
  localparam int STEP_BIT = 12;
  localparam int ADDR_MSB = 11;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;
  // System clock and link timing
  localparam real CLK_NS = 8.0;
  localparam real SCLK_HALF_NS = 80.0;
  localparam real CS_SETUP_NS = 1.5;
  localparam real WR_GAP_NS = 100.0;
  localparam real RD_WAIT_NS = 222.6;
  localparam real CS_HOLD_NS = 445.0;
  localparam int SCLK_HALF_CYC = int'($ceil(SCLK_HALF_NS / CLK_NS));
  localparam int CS_SETUP_CYC = int'($ceil(CS_SETUP_NS / CLK_NS));
  localparam int WR_GAP_CYC = int'($ceil(WR_GAP_NS / CLK_NS));
  localparam int RD_WAIT_CYC = int'($ceil(RD_WAIT_NS / CLK_NS));
  localparam int CS_HOLD_CYC = int'($ceil(CS_HOLD_NS / CLK_NS));
  // Host register offsets
  localparam int HREG_W = 3;
  localparam logic [HREG_W-1:0] HREG_CMD = 3'h0;
  localparam logic [HREG_W-1:0] HREG_TXD = 3'h1;
  localparam logic [HREG_W-1:0] HREG_RXD = 3'h2;
  localparam logic [HREG_W-1:0] HREG_END = 3'h3;
  localparam logic [HREG_W-1:0] HREG_STAT = 3'h4;
  // Host status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_OPEN = 1;
  localparam int STAT_RXV = 2;
  localparam int STAT_WDONE = 3;
endpackage

// ==== shrp_if.sv ====
// Four-wire link between host and device
`timescale 1ns/1ps
`default_nettype none
interface shrp_if;
  logic sclk;
  logic serial_in;
  logic cs_n;
  logic serial_chain_out;
  modport host (
    output sclk,
    output serial_in,
    output cs_n,
    input  serial_chain_out
  );
  modport dev (
    input  sclk,
    input  serial_in,
    input  cs_n,
    output serial_chain_out
  );
endinterface
`default_nettype wire

// ==== shrp_dev.sv ====
// Device end: serial register port with JTAG pin sharing
`timescale 1ns/1ps
`default_nettype none
module shrp_dev #(
  parameter int DEPTH = 16
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         nrst_in,
  input  wire logic                         port_sel_strap_in,
  shrp_if.dev                               link,
  output logic                              jtag_tck_out,
  output logic                              jtag_tdi_out,
  output logic                              jtag_tms_out,
  input  wire logic                         jtag_tdo_in,
  input  wire logic                         loc_wr_in,
  input  wire logic [shrp_pkg::ADDR_W-1:0]  loc_addr_in,
  input  wire logic [shrp_pkg::WORD_W-1:0]  loc_data_in,
  output logic                              wr_stb_out,
  output logic [shrp_pkg::ADDR_W-1:0]       wr_addr_out,
  output logic [shrp_pkg::WORD_W-1:0]       wr_data_out
);

  typedef enum logic [1:0] {
    SHRP_CMD,
    SHRP_WR,
    SHRP_RD,
    SHRP_DONE
  } shrp_dst_t;

  localparam logic [shrp_pkg::ADDR_W-1:0] DEPTH_A = shrp_pkg::ADDR_W'(DEPTH);

  // Address lies inside the implemented word array
  function automatic logic shrp_fits(input logic [shrp_pkg::ADDR_W-1:0] a);
    shrp_fits = (a < DEPTH_A);
  endfunction

  // Pin synchronisers
  logic strap_s1_r;
  logic strap_s2_r;
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_d_r;
  logic serial_in_s1_r;
  logic serial_in_s2_r;
  logic cs_s1_r;
  logic cs_s2_r;

  // Engine state
  shrp_dst_t                    st_r;
  shrp_dst_t                    st_nxt;
  logic [shrp_pkg::CNT_W-1:0]   cnt_r;
  logic [shrp_pkg::CNT_W-1:0]   cnt_nxt;
  logic [shrp_pkg::WORD_W-1:0]  sh_r;
  logic [shrp_pkg::WORD_W-1:0]  sh_nxt;
  logic [shrp_pkg::WORD_W-1:0]  out_r;
  logic [shrp_pkg::WORD_W-1:0]  out_nxt;
  logic [shrp_pkg::ADDR_W-1:0]  addr_r;
  logic [shrp_pkg::ADDR_W-1:0]  addr_nxt;
  logic                         step_r;
  logic                         step_nxt;
  logic                         load_r;
  logic                         load_nxt;
  logic                         wr_stb_r;
  logic                         wr_stb_nxt;
  logic [shrp_pkg::ADDR_W-1:0]  wr_addr_r;
  logic [shrp_pkg::ADDR_W-1:0]  wr_addr_nxt;
  logic [shrp_pkg::WORD_W-1:0]  wr_data_r;
  logic [shrp_pkg::WORD_W-1:0]  wr_data_nxt;
  logic [shrp_pkg::WORD_W-1:0]  mem_r [DEPTH];

  logic                         jtag_mode;
  logic                         sclk_rise;
  logic                         sclk_fall;
  logic [shrp_pkg::WORD_W-1:0]  word;
  logic                         mem_we;
  logic [shrp_pkg::ADDR_W-1:0]  mem_wa;
  logic [shrp_pkg::WORD_W-1:0]  mem_wd;

  // Two flops on the strap and each link input, edge history behind sclk only
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      sclk_s1_r  <= 1'b0;
      sclk_s2_r  <= 1'b0;
      sclk_d_r   <= 1'b0;
      serial_in_s1_r  <= 1'b0;
      serial_in_s2_r  <= 1'b0;
      cs_s1_r    <= 1'b1;
      cs_s2_r    <= 1'b1;
    end else begin
      strap_s1_r <= port_sel_strap_in;
      strap_s2_r <= strap_s1_r;
      sclk_s1_r  <= link.sclk;
      sclk_s2_r  <= sclk_s1_r;
      sclk_d_r   <= sclk_s2_r;
      serial_in_s1_r  <= link.serial_in;
      serial_in_s2_r  <= serial_in_s1_r;
      cs_s1_r    <= link.cs_n;
      cs_s2_r    <= cs_s1_r;
    end
  end

  // Edge detect on the synchronised clock
  assign jtag_mode = strap_s2_r;
  assign sclk_rise = sclk_s2_r & ~sclk_d_r;
  assign sclk_fall = ~sclk_s2_r & sclk_d_r;
  assign word      = {sh_r[shrp_pkg::WORD_W-2:0], serial_in_s2_r};

  // Command decode, write storage and read shifting
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    out_nxt     = out_r;
    addr_nxt    = addr_r;
    step_nxt    = step_r;
    load_nxt    = load_r;
    wr_stb_nxt  = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    mem_we      = 1'b0;
    mem_wa      = addr_r;
    mem_wd      = word;
    if (cs_s2_r || jtag_mode) begin
      st_nxt   = SHRP_CMD;
      cnt_nxt  = '0;
      load_nxt = 1'b0;
      out_nxt  = shrp_pkg::WORD_RST;
    end else if (sclk_rise) begin
      sh_nxt  = word;
      cnt_nxt = cnt_r + 1'b1;
      if (st_r == SHRP_CMD) begin
        out_nxt = shrp_pkg::WORD_RST;
      end
      if (cnt_r == shrp_pkg::LAST_BIT) begin
        case (st_r)
          SHRP_CMD: begin
            // Bits 14 and 13 are never looked at
            addr_nxt = word[shrp_pkg::ADDR_MSB:0];
            step_nxt = word[shrp_pkg::STEP_BIT];
            if (word[shrp_pkg::RW_BIT]) begin
              st_nxt   = SHRP_RD;
              load_nxt = 1'b1;
            end else begin
              st_nxt = SHRP_WR;
            end
          end
          SHRP_WR: begin
            // Every selected device stores the same word if the address fits its array
            mem_we      = shrp_fits(addr_r);
            wr_stb_nxt  = 1'b1;
            wr_addr_nxt = addr_r;
            wr_data_nxt = word;
            if (step_r) begin
              addr_nxt = addr_r + 1'b1;
            end else begin
              st_nxt = SHRP_DONE;
            end
          end
          SHRP_RD: begin
            // Last read bit must stand until the next fall
            if (step_r) begin
              addr_nxt = addr_r + 1'b1;
              load_nxt = 1'b1;
            end
          end
          default: begin
            st_nxt = SHRP_DONE;
          end
        endcase
      end
    end else if (sclk_fall && st_r == SHRP_RD) begin
      if (load_r) begin
        // First bit appears after the word's last falling edge
        out_nxt  = shrp_fits(addr_r) ? mem_r[addr_r[$clog2(DEPTH)-1:0]] : '0;
        load_nxt = 1'b0;
      end else begin
        out_nxt = {out_r[shrp_pkg::WORD_W-2:0], 1'b0};
      end
    end
    // Local status writes yield to a serial write
    if (!mem_we && loc_wr_in && shrp_fits(loc_addr_in)) begin
      mem_we = 1'b1;
      mem_wa = loc_addr_in;
      mem_wd = loc_data_in;
    end
  end

  // Engine registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_r      <= SHRP_CMD;
      cnt_r     <= '0;
      sh_r      <= shrp_pkg::WORD_RST;
      out_r     <= shrp_pkg::WORD_RST;
      addr_r    <= '0;
      step_r    <= 1'b0;
      load_r    <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= shrp_pkg::WORD_RST;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      out_r     <= out_nxt;
      addr_r    <= addr_nxt;
      step_r    <= step_nxt;
      load_r    <= load_nxt;
      wr_stb_r  <= wr_stb_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // Register array
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= shrp_pkg::WORD_RST;
      end
    end else if (mem_we) begin
      mem_r[mem_wa[$clog2(DEPTH)-1:0]] <= mem_wd;
    end
  end

  // Pin routing: loop-through, read data or JTAG
  always_comb begin
    if (jtag_mode) begin
      link.serial_chain_out = jtag_tdo_in;
    end else if (st_r == SHRP_RD && !cs_s2_r) begin
      link.serial_chain_out = out_r[shrp_pkg::WORD_W-1];
    end else begin
      link.serial_chain_out = link.serial_in;
    end
  end

  // JTAG side sees the pins only in test mode
  assign jtag_tck_out = jtag_mode & link.sclk;
  assign jtag_tdi_out = jtag_mode & link.serial_in;
  assign jtag_tms_out = jtag_mode & ~link.cs_n;
  assign wr_stb_out   = wr_stb_r;
  assign wr_addr_out  = wr_addr_r;
  assign wr_data_out  = wr_data_r;

endmodule
`default_nettype wire

// ==== shrp_host.sv ====
// Host end: command registers driving the serial link
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module shrp_host (
  input  wire logic                         clk_sys_in,
  input  wire logic                         nrst_in,
  shrp_if.host                              link,
  input  wire logic [shrp_pkg::HREG_W-1:0]  reg_addr_in,
  input  wire logic [shrp_pkg::WORD_W-1:0]  reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic [shrp_pkg::WORD_W-1:0]       reg_rdata_out
);

  typedef enum logic [2:0] {
    SHRP_IDLE,
    SHRP_SETUP,
    SHRP_SHIFT,
    SHRP_GAP,
    SHRP_OPEN,
    SHRP_HOLD
  } shrp_hst_t;

  localparam logic [shrp_pkg::TIM_W-1:0] T_HALF = shrp_pkg::TIM_W'(shrp_pkg::SCLK_HALF_CYC - 1);
  localparam logic [shrp_pkg::TIM_W-1:0] T_SET = shrp_pkg::TIM_W'(shrp_pkg::CS_SETUP_CYC - 1);
  localparam logic [shrp_pkg::TIM_W-1:0] T_WGAP = shrp_pkg::TIM_W'(shrp_pkg::WR_GAP_CYC - 1);
  localparam logic [shrp_pkg::TIM_W-1:0] T_RWAIT = shrp_pkg::TIM_W'(shrp_pkg::RD_WAIT_CYC - 1);
  localparam logic [shrp_pkg::TIM_W-1:0] T_HOLD = shrp_pkg::TIM_W'(shrp_pkg::CS_HOLD_CYC - 1);

  logic                         sdo_s1_r;
  logic                         sdo_s2_r;
  shrp_hst_t                    st_r;
  shrp_hst_t                    st_nxt;
  logic [shrp_pkg::TIM_W-1:0]   tim_r;
  logic [shrp_pkg::TIM_W-1:0]   tim_nxt;
  logic [shrp_pkg::CNT_W-1:0]   bit_r;
  logic [shrp_pkg::CNT_W-1:0]   bit_nxt;
  logic [shrp_pkg::WORD_W-1:0]  tx_r;
  logic [shrp_pkg::WORD_W-1:0]  tx_nxt;
  logic [shrp_pkg::WORD_W-1:0]  rx_r;
  logic [shrp_pkg::WORD_W-1:0]  rx_nxt;
  logic [shrp_pkg::WORD_W-1:0]  rxd_r;
  logic [shrp_pkg::WORD_W-1:0]  rxd_nxt;
  logic                         rw_r;
  logic                         rw_nxt;
  logic                         step_r;
  logic                         step_nxt;
  logic                         is_cmd_r;
  logic                         is_cmd_nxt;
  logic                         wdone_r;
  logic                         wdone_nxt;
  logic                         rxv_r;
  logic                         rxv_nxt;
  logic                         sclk_r;
  logic                         sclk_nxt;
  logic                         sdi_r;
  logic                         sdi_nxt;
  logic                         cs_n_r;
  logic                         cs_n_nxt;
  logic [shrp_pkg::WORD_W-1:0]  rdata_r;
  logic [shrp_pkg::WORD_W-1:0]  rdata_nxt;
  logic                         wr_cmd;
  logic                         word_ok;

  // Returning chain data is from another domain
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sdo_s1_r <= 1'b0;
      sdo_s2_r <= 1'b0;
    end else begin
      sdo_s1_r <= link.serial_chain_out;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  assign wr_cmd  = reg_wr_in && reg_addr_in == shrp_pkg::HREG_CMD;
  assign word_ok = step_r || !wdone_r;

  // Order handling, clock generation and shifting
  always_comb begin
    st_nxt     = st_r;
    tim_nxt    = tim_r;
    bit_nxt    = bit_r;
    tx_nxt     = tx_r;
    rx_nxt     = rx_r;
    rxd_nxt    = rxd_r;
    rw_nxt     = rw_r;
    step_nxt   = step_r;
    is_cmd_nxt = is_cmd_r;
    wdone_nxt  = wdone_r;
    rxv_nxt    = rxv_r;
    sclk_nxt   = sclk_r;
    sdi_nxt    = sdi_r;
    cs_n_nxt   = cs_n_r;
    rdata_nxt  = '0;
    if (reg_rd_in && reg_addr_in == shrp_pkg::HREG_RXD) begin
      rxv_nxt = 1'b0;
    end
    case (st_r)
      SHRP_IDLE: begin
        if (wr_cmd) begin
          // Reserved bits go out as zero
          tx_nxt     = reg_wdata_in & 16'h9fff;
          rw_nxt     = reg_wdata_in[shrp_pkg::RW_BIT];
          step_nxt   = reg_wdata_in[shrp_pkg::STEP_BIT];
          is_cmd_nxt = 1'b1;
          wdone_nxt  = 1'b0;
          cs_n_nxt   = 1'b0;
          sdi_nxt    = reg_wdata_in[shrp_pkg::RW_BIT];
          tim_nxt    = T_SET;
          st_nxt     = SHRP_SETUP;
        end
      end
      SHRP_SETUP: begin
        if (tim_r == '0) begin
          tim_nxt = T_HALF;
          bit_nxt = '0;
          st_nxt  = SHRP_SHIFT;
        end else begin
          tim_nxt = tim_r - 1'b1;
        end
      end
      SHRP_SHIFT: begin
        if (tim_r != '0) begin
          tim_nxt = tim_r - 1'b1;
        end else if (!sclk_r) begin
          sclk_nxt = 1'b1;
          rx_nxt   = {rx_r[shrp_pkg::WORD_W-2:0], sdo_s2_r};
          tim_nxt  = T_HALF;
        end else begin
          sclk_nxt = 1'b0;
          if (bit_r == shrp_pkg::LAST_BIT) begin
            tim_nxt = rw_r ? T_RWAIT : T_WGAP;
            st_nxt  = SHRP_GAP;
            if (!is_cmd_r) begin
              wdone_nxt = 1'b1;
              if (rw_r) begin
                rxd_nxt = rx_r;
                rxv_nxt = 1'b1;
              end
            end
          end else begin
            bit_nxt = bit_r + 1'b1;
            tx_nxt  = {tx_r[shrp_pkg::WORD_W-2:0], 1'b0};
            sdi_nxt = tx_r[shrp_pkg::WORD_W-2];
            tim_nxt = T_HALF;
          end
        end
      end
      SHRP_GAP: begin
        if (tim_r == '0) begin
          st_nxt = SHRP_OPEN;
        end else begin
          tim_nxt = tim_r - 1'b1;
        end
      end
      SHRP_OPEN: begin
        if (reg_wr_in && reg_addr_in == shrp_pkg::HREG_END) begin
          tim_nxt = T_HOLD;
          st_nxt  = SHRP_HOLD;
        end else if (reg_wr_in && word_ok &&
                     ((reg_addr_in == shrp_pkg::HREG_TXD && !rw_r) ||
                      (reg_addr_in == shrp_pkg::HREG_RXD && rw_r))) begin
          tx_nxt     = rw_r ? '0 : reg_wdata_in;
          sdi_nxt    = rw_r ? 1'b0 : reg_wdata_in[shrp_pkg::WORD_W-1];
          is_cmd_nxt = 1'b0;
          tim_nxt    = T_HALF;
          bit_nxt    = '0;
          st_nxt     = SHRP_SHIFT;
        end
      end
      SHRP_HOLD: begin
        if (tim_r == '0) begin
          cs_n_nxt = 1'b1;
          sdi_nxt  = 1'b0;
          st_nxt   = SHRP_IDLE;
        end else begin
          tim_nxt = tim_r - 1'b1;
        end
      end
      default: begin
        st_nxt = SHRP_IDLE;
      end
    endcase
    if (reg_rd_in) begin
      case (reg_addr_in)
        shrp_pkg::HREG_RXD: rdata_nxt = rxd_r;
        shrp_pkg::HREG_STAT: begin
          rdata_nxt[shrp_pkg::STAT_BUSY]  = st_r != SHRP_IDLE && st_r != SHRP_OPEN;
          rdata_nxt[shrp_pkg::STAT_OPEN]  = st_r == SHRP_OPEN;
          rdata_nxt[shrp_pkg::STAT_RXV]   = rxv_r;
          rdata_nxt[shrp_pkg::STAT_WDONE] = wdone_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Host registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_r     <= SHRP_IDLE;
      tim_r    <= '0;
      bit_r    <= '0;
      tx_r     <= shrp_pkg::WORD_RST;
      rx_r     <= shrp_pkg::WORD_RST;
      rxd_r    <= shrp_pkg::WORD_RST;
      rw_r     <= 1'b0;
      step_r   <= 1'b0;
      is_cmd_r <= 1'b0;
      wdone_r  <= 1'b0;
      rxv_r    <= 1'b0;
      sclk_r   <= 1'b0;
      sdi_r    <= 1'b0;
      cs_n_r   <= 1'b1;
      rdata_r  <= shrp_pkg::WORD_RST;
    end else begin
      st_r     <= st_nxt;
      tim_r    <= tim_nxt;
      bit_r    <= bit_nxt;
      tx_r     <= tx_nxt;
      rx_r     <= rx_nxt;
      rxd_r    <= rxd_nxt;
      rw_r     <= rw_nxt;
      step_r   <= step_nxt;
      is_cmd_r <= is_cmd_nxt;
      wdone_r  <= wdone_nxt;
      rxv_r    <= rxv_nxt;
      sclk_r   <= sclk_nxt;
      sdi_r    <= sdi_nxt;
      cs_n_r   <= cs_n_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign link.sclk      = sclk_r;
  assign link.serial_in = sdi_r;
  assign link.cs_n      = cs_n_r;
  assign reg_rdata_out  = rdata_r;

endmodule
`default_nettype wire

// ==== shrp_properties.sv ====
// Link checker for the serial host register port
`timescale 1ns/1ps
`default_nettype none
module shrp_properties (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic port_sel_strap_in,
  input  wire logic sclk,
  input  wire logic serial_in,
  input  wire logic cs_n,
  input  wire logic serial_chain_out
);
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  low_r, low_nxt, aft_r, aft_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [2:0]  hi_r, hi_nxt;
  logic        sclk_r, first_r, first_nxt, rd_r, rd_nxt, rise;
  // Bit position, idle lengths and read tracking
  always_comb begin
    rise = sclk & ~sclk_r;
    bit_nxt = cs_n ? 4'h0 : bit_r + {3'h0, rise};
    first_nxt = cs_n ? 1'b1 : first_r & ~(rise & (bit_r == 4'hf));
    low_nxt = sclk ? 8'h00 : low_r + {7'h0, low_r != 8'hff};
    aft_nxt = rise ? 8'h00 : aft_r + {7'h0, aft_r != 8'hff};
    sh_nxt = rise ? {sh_r[14:0], serial_in} : sh_r;
    hi_nxt = cs_n ? hi_r + {2'h0, hi_r != 3'h7} : 3'h0;
    rd_nxt = (hi_r == 3'h5) ? 1'b0 : rd_r | (rise & first_r & (bit_r == 4'hf) & sh_r[14]);
  end
  // Register the tracking state
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sclk_r  <= 1'b0;
      bit_r   <= 4'h0;
      first_r <= 1'b1;
      low_r   <= 8'h00;
      aft_r   <= 8'hff;
      sh_r    <= 16'h0000;
      hi_r    <= 3'h7;
      rd_r    <= 1'b0;
    end else begin
      sclk_r  <= sclk;
      bit_r   <= bit_nxt;
      first_r <= first_nxt;
      low_r   <= low_nxt;
      aft_r   <= aft_nxt;
      sh_r    <= sh_nxt;
      hi_r    <= hi_nxt;
      rd_r    <= rd_nxt;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  sequence s_high_phase;
    sclk [*8];
  endsequence
  sequence s_strap_quiet;
    !port_sel_strap_in && !$past(port_sel_strap_in) && !$past(port_sel_strap_in, 2) && !$past(port_sel_strap_in, 4);
  endsequence
  AST_SCLK_HIGH: assert property (rise |-> s_high_phase)
    else $error("link clock high phase too short");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*5])
    else $error("link clock low phase too short");
  AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk [*2])
    else $error("clock rose with select");
  AST_SCLK_SELECTED: assert property (sclk |-> !cs_n)
    else $error("clock high while not selected");
  AST_WORD_GAP: assert property (rise && bit_r == 4'h0 && !first_r |-> low_r >= 8'd13)
    else $error("word gap too short");
  AST_READ_WAIT: assert property (rise && bit_r == 4'h0 && !first_r && rd_r |-> low_r >= 8'd28)
    else $error("read wait too short");
  AST_CS_HOLD: assert property ($rose(cs_n) |-> aft_r >= 8'd56)
    else $error("select released too soon");
  AST_WHOLE_WORDS: assert property ($rose(cs_n) |-> bit_r == 4'h0)
    else $error("frame ended inside a word");
  AST_READ_STABLE: assert property (rd_r && rise && !first_r |-> $stable(serial_chain_out) [*8])
    else $error("read bit moved while clock high");
  AST_CHAIN_COPY: assert property ((!rd_r and s_strap_quiet) |-> serial_chain_out == serial_in)
    else $error("chain output differs from input");
endmodule
`default_nettype wire

// ==== tb_serial_host_register_port.sv ====
// Bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb_serial_host_register_port;
  logic        clk_sys_in, nrst_in, strap, tdo, loc_wr, reg_wr, reg_rd, tck, tdi, tms, wr_stb;
  logic [11:0] loc_addr, wr_addr;
  logic [15:0] loc_data, reg_wdata, rdata, wr_data;
  logic [2:0]  reg_addr;
  logic [27:0] wq[$];
  int          err_total, n_checks;
  shrp_if link_bus ();
  shrp_host u_shrp_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .link(link_bus), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata));
  shrp_dev #(.DEPTH(16)) u_shrp_dev (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .port_sel_strap_in(strap),
    .link(link_bus), .jtag_tck_out(tck), .jtag_tdi_out(tdi), .jtag_tms_out(tms), .jtag_tdo_in(tdo),
    .loc_wr_in(loc_wr), .loc_addr_in(loc_addr), .loc_data_in(loc_data), .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data));
  shrp_properties u_shrp_properties (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .port_sel_strap_in(strap),
    .sclk(link_bus.sclk), .serial_in(link_bus.serial_in), .cs_n(link_bus.cs_n),
    .serial_chain_out(link_bus.serial_chain_out));
  // System clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Collect device write strobes
  always @(posedge clk_sys_in) begin
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
  end
  task automatic chk_val(input logic [27:0] got, input logic [27:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({27'h0, got}, {27'h0, exp});
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded status poll
  task automatic wait_stat(input int b, input logic v);
    logic [15:0] s;
    for (int i = 0; i < 3000; i++) begin
      reg_read(shrp_pkg::HREG_STAT, s);
      if (s[b] === v) return;
    end
    err_total++;
    finish_test();
  endtask
  // One framed access: command, n data words, end
  task automatic xfer(input logic [15:0] cmd, input logic [47:0] w, input int n);
    logic [15:0] v;
    wait_stat(shrp_pkg::STAT_BUSY, 1'b0);
    reg_write(shrp_pkg::HREG_CMD, cmd);
    for (int i = 0; i < n; i++) begin
      wait_stat(shrp_pkg::STAT_OPEN, 1'b1);
      if (cmd[15]) begin
        reg_write(shrp_pkg::HREG_RXD, 16'h0000);
        wait_stat(shrp_pkg::STAT_RXV, 1'b1);
        reg_read(shrp_pkg::HREG_RXD, v);
        chk_val({12'h000, v}, {12'h000, w[47-16*i -: 16]});
      end else begin
        reg_write(shrp_pkg::HREG_TXD, w[47-16*i -: 16]);
      end
    end
    wait_stat(shrp_pkg::STAT_OPEN, 1'b1);
    reg_write(shrp_pkg::HREG_END, 16'h0000);
    wait_stat(shrp_pkg::STAT_BUSY, 1'b0);
  endtask
  task automatic chk_wr(input logic [27:0] exp);
    logic [27:0] got;
    got = 28'hfffffff;
    if (wq.size() > 0) got = wq.pop_front();
    chk_val(got, exp);
  endtask
  // Main sequence
  initial begin
    nrst_in = 1'b0;
    strap = 1'b0;
    tdo = 1'b0;
    loc_wr = 1'b0;
    loc_addr = 12'h000;
    loc_data = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    // Writes: reserved bits set, extra word on non-step, stepped burst
    xfer(16'h6005, 48'ha5c3_0000_0000, 1);
    chk_wr({12'h005, 16'ha5c3});
    xfer(16'h0007, 48'h1234_5678_0000, 2);
    chk_wr({12'h007, 16'h1234});
    chk_val(28'(wq.size()), 28'h0);
    xfer(16'h1002, 48'h0f0f_8001_7ffe, 3);
    chk_wr({12'h002, 16'h0f0f});
    chk_wr({12'h003, 16'h8001});
    chk_wr({12'h004, 16'h7ffe});
    // Local write, then reads back over the link
    @(posedge clk_sys_in);
    loc_addr <= 12'h009;
    loc_data <= 16'hbeef;
    loc_wr <= 1'b1;
    @(posedge clk_sys_in);
    loc_wr <= 1'b0;
    xfer(16'h9003, 48'h8001_7ffe_0000, 2);
    xfer(16'h8007, 48'h1234_0000_0000, 1);
    xfer(16'he005, 48'ha5c3_0000_0000, 1);
    xfer(16'h8009, 48'hbeef_0000_0000, 1);
    xfer(16'h8020, 48'h0000_0000_0000, 1);
    // Strap high hands the pins to the test port
    strap <= 1'b1;
    tdo <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1 chk_bit(link_bus.serial_chain_out, 1'b1);
    chk_bit(tms, 1'b0);
    tdo <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1 chk_bit(link_bus.serial_chain_out, 1'b0);
    // A frame in test mode reaches only the test pins
    reg_write(shrp_pkg::HREG_CMD, 16'h8006);
    repeat (4) @(posedge clk_sys_in);
    #1 chk_bit(tms, 1'b1);
    chk_bit(tdi, 1'b1);
    repeat (10) @(posedge clk_sys_in);
    #1 chk_bit(tck, 1'b1);
    chk_bit(link_bus.serial_chain_out, 1'b0);
    wait_stat(shrp_pkg::STAT_OPEN, 1'b1);
    reg_write(shrp_pkg::HREG_END, 16'h0000);
    wait_stat(shrp_pkg::STAT_BUSY, 1'b0);
    strap <= 1'b0;
    tdo <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1 chk_bit(link_bus.serial_chain_out, 1'b0);
    chk_bit(tck, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
